// ==== core/rcd_cfg_top.sv ====
// Purpose: Paged register map, strap capture, equalizer search and output fan-out
// Assumes: Register requests come already framed by the SPI/SMBus front end on CLK_I
// Notes:   Straps are tri-level codes sampled once after reset release
`timescale 1ns/1ps
`default_nettype none
`include "rcd_cfg_map.svh"
module rcd_cfg_top
    import rcd_cfg_pkg::*;
#(
    parameter int         BOOST_STEPS = 16,
    parameter logic [7:0] DEV_ID      = `RCD_DEV_ID_VAL
) (
    // Clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    // Strap pins, tri-level codes
    input  wire logic [1:0] MODE_STRAP_I,
    input  wire logic [1:0] LOOPBACK_SELECT_STRAP_I,
    input  wire logic [1:0] SECONDARY_OUTPUT_SELECT_STRAP_I,
    // Register access from the serial front end
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output logic      [7:0] REG_RDATA_O,
    output logic            REG_ACK_O,
    output logic            SPI_MODE_O,
    output logic            STRAP_DONE_O,
    // Rate detector and eye monitor
    input  wire logic       SIGNAL_DET_I,
    input  wire logic [2:0] RATE_CODE_I,
    input  wire logic       EYE_VALID_I,
    input  wire logic [7:0] EYE_H_I,
    input  wire logic [7:0] EYE_V_I,
    output logic            EYE_MON_EN_O,
    output logic [3:0]      EQ_BOOST_O,
    output logic            BYPASS_O,
    output logic            LOCK_IND_O,
    // Serial data path
    input  wire logic       DIFF_SERIAL_INPUT_I,
    output logic            LOOPBACK_DIFF_OUTPUT_O,
    output logic            PRIMARY_CABLE_OUTPUT_O,
    output logic            SECONDARY_CABLE_OUTPUT_O
);
    localparam int BW = $clog2(BOOST_STEPS);

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture
    logic [1:0]    mode_s1_q, mode_s2_q, lb_s1_q, lb_s2_q, sec_s1_q, sec_s2_q;
    logic [7:0]    settle_q, settle_d;
    logic          strap_done_q, strap_done_d;
    rcd_strap_type strap_q, strap_d;

    always_comb begin
        settle_d     = settle_q;
        strap_done_d = strap_done_q;
        strap_d      = strap_q;
        if (!strap_done_q) begin
            if (settle_q == `RCD_STRAP_SETTLE) begin
                strap_done_d         = 1'b1;
                // Floating or high picks SPI, low picks SMBus
                strap_d.spi_mode     = (mode_s2_q == LVL_F) || (mode_s2_q == LVL_H);
                // Only a firm low enables the loop-back; high and unknown levels keep it off
                strap_d.loopback_en  = (lb_s2_q == LVL_L);
                strap_d.secondary_en = (sec_s2_q == LVL_L);
            end else begin
                settle_d = settle_q + 8'h01;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mode_s1_q    <= 2'h0;
            mode_s2_q    <= 2'h0;
            lb_s1_q      <= 2'h0;
            lb_s2_q      <= 2'h0;
            sec_s1_q     <= 2'h0;
            sec_s2_q     <= 2'h0;
            settle_q     <= 8'h00;
            strap_done_q <= 1'b0;
            strap_q      <= '0;
        end else begin
            mode_s1_q    <= MODE_STRAP_I;
            mode_s2_q    <= mode_s1_q;
            lb_s1_q      <= LOOPBACK_SELECT_STRAP_I;
            lb_s2_q      <= lb_s1_q;
            sec_s1_q     <= SECONDARY_OUTPUT_SELECT_STRAP_I;
            sec_s2_q     <= sec_s1_q;
            settle_q     <= settle_d;
            strap_done_q <= strap_done_d;
            strap_q      <= strap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Paged register file
    rcd_req_type      req;
    rcd_eq_state_type eq_q, eq_d;
    logic [2:0]       page_q, page_d;
    logic [7:0]       eye_mon_q, eye_mon_d, lock_cfg_q, lock_cfg_d;
    logic [7:0]       eq_mode_q, eq_mode_d, drv_out_q, drv_out_d;
    logic [7:0]       rdata_q, rdata_d;
    logic             ack_q, ack_d;
    logic             page_legal, locked, rate_ok;
    logic [BW-1:0]    boost_q, boost_d, best_q, best_d;
    logic [7:0]       bank_rdata [3];
    logic [2:0]       bank_wr;

    assign req        = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};
    assign page_legal = (page_q == `RCD_PAGE_SHARE) || (page_q == `RCD_PAGE_EQ) || (page_q == `RCD_PAGE_DRV);

    localparam logic [2:0] PAGE_CODES [3] = '{`RCD_PAGE_SHARE, `RCD_PAGE_EQ, `RCD_PAGE_DRV};

    // One storage bank per defined page for the rest of the map
    for (genvar p = 0; p < 3; p++) begin : g_bank
        assign bank_wr[p] = req.wr && (req.addr != `RCD_PAGE_SEL_ADDR) && (page_q == PAGE_CODES[p]);
        rcd_page_bank #(
            .DEPTH (256)
        ) u_bank (
            .clk_i   (CLK_I),
            .rst_i   (RST_I),
            .wr_i    (bank_wr[p]),
            .addr_i  (req.addr),
            .wdata_i (req.wdata),
            .rdata_o (bank_rdata[p])
        );
    end

    always_comb begin
        page_d     = page_q;
        eye_mon_d  = eye_mon_q;
        lock_cfg_d = lock_cfg_q;
        eq_mode_d  = eq_mode_q;
        drv_out_d  = drv_out_q;
        rdata_d    = rdata_q;
        ack_d      = req.wr || req.rd;
        if (req.wr) begin
            if (req.addr == `RCD_PAGE_SEL_ADDR) begin
                page_d = req.wdata[2:0];
            end else if (page_q == `RCD_PAGE_SHARE && req.addr == `RCD_LOCK_CFG_ADDR) begin
                lock_cfg_d = req.wdata;
            end else if (page_q == `RCD_PAGE_EQ && req.addr == `RCD_EYE_MON_ADDR) begin
                eye_mon_d = req.wdata;
            end else if (page_q == `RCD_PAGE_EQ && req.addr == `RCD_EQ_MODE_ADDR) begin
                eq_mode_d = req.wdata;
            end else if (page_q == `RCD_PAGE_DRV && req.addr == `RCD_DRV_OUT_ADDR) begin
                drv_out_d = req.wdata;
            end
        end
        if (req.rd) begin
            if (req.addr == `RCD_PAGE_SEL_ADDR) begin
                rdata_d = {5'h00, page_q};
            end else if (!page_legal) begin
                rdata_d = 8'h00;
            end else if (page_q == `RCD_PAGE_SHARE) begin
                case (req.addr)
                    `RCD_DEV_ID_ADDR:   rdata_d = DEV_ID;
                    `RCD_LOCK_CFG_ADDR: rdata_d = lock_cfg_q;
                    default:            rdata_d = bank_rdata[0];
                endcase
            end else if (page_q == `RCD_PAGE_EQ) begin
                case (req.addr)
                    `RCD_EYE_MON_ADDR: rdata_d = eye_mon_q;
                    `RCD_EQ_MODE_ADDR: rdata_d = eq_mode_q;
                    `RCD_EQ_STAT_ADDR: rdata_d = {locked, BYPASS_O, 2'h0, 4'(best_q)};
                    default:           rdata_d = bank_rdata[1];
                endcase
            end else begin
                case (req.addr)
                    `RCD_DRV_OUT_ADDR: rdata_d = drv_out_q;
                    default:           rdata_d = bank_rdata[2];
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            page_q     <= `RCD_PAGE_SHARE;
            eye_mon_q  <= `RCD_EYE_MON_RST;
            lock_cfg_q <= `RCD_LOCK_CFG_RST;
            eq_mode_q  <= `RCD_EQ_MODE_RST;
            drv_out_q  <= `RCD_DRV_OUT_RST;
            rdata_q    <= 8'h00;
            ack_q      <= 1'b0;
        end else begin
            page_q     <= page_d;
            eye_mon_q  <= eye_mon_d;
            lock_cfg_q <= lock_cfg_d;
            eq_mode_q  <= eq_mode_d;
            drv_out_q  <= drv_out_d;
            rdata_q    <= rdata_d;
            ack_q      <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Equalizer search and lock
    logic [8:0] best_m_q, best_m_d;
    logic [8:0] eye_sum;
    logic       adaptive, mon_en, sig_ok;

    assign adaptive = eq_mode_q[`RCD_EQ_ADAPT_BIT];
    assign mon_en   = eye_mon_q[`RCD_EYE_MON_BIT];
    assign rate_ok  = (RATE_CODE_I >= 3'h1) && (RATE_CODE_I <= 3'h5);
    assign sig_ok   = SIGNAL_DET_I && rate_ok;
    assign eye_sum  = {1'b0, EYE_H_I} + {1'b0, EYE_V_I};
    assign locked   = (eq_q == EQ_LOCK) || (eq_q == EQ_MANUAL);

    always_comb begin
        eq_d     = eq_q;
        boost_d  = boost_q;
        best_d   = best_q;
        best_m_d = best_m_q;
        case (eq_q)
            EQ_IDLE: begin
                if (sig_ok) begin
                    boost_d  = '0;
                    best_d   = '0;
                    best_m_d = 9'h000;
                    eq_d     = adaptive ? EQ_SWEEP : EQ_MANUAL;
                end
            end
            EQ_SWEEP: begin
                if (!sig_ok || !adaptive) begin
                    eq_d = EQ_IDLE;
                end else if (EYE_VALID_I && mon_en) begin
                    // Strictly larger keeps the lowest boost among equal eyes
                    if (eye_sum > best_m_q) begin
                        best_d   = boost_q;
                        best_m_d = eye_sum;
                    end
                    if (boost_q == BW'(BOOST_STEPS - 1)) begin
                        eq_d = EQ_APPLY;
                    end else begin
                        boost_d = boost_q + BW'(1);
                    end
                end
            end
            EQ_APPLY: begin
                // Losing the signal here must not fall through into lock
                if (!sig_ok || !adaptive) begin
                    eq_d = EQ_IDLE;
                end else begin
                    boost_d = best_q;
                    eq_d    = EQ_LOCK;
                end
            end
            EQ_LOCK: begin
                // Monitor state is not consulted once locked
                if (!sig_ok || !adaptive) begin
                    eq_d = EQ_IDLE;
                end
            end
            EQ_MANUAL: begin
                boost_d = eq_mode_q[`RCD_EQ_BOOST_LSB +: BW];
                if (!sig_ok || adaptive) begin
                    eq_d = EQ_IDLE;
                end
            end
            default: eq_d = EQ_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            eq_q     <= EQ_IDLE;
            boost_q  <= '0;
            best_q   <= '0;
            best_m_q <= 9'h000;
        end else begin
            eq_q     <= eq_d;
            boost_q  <= boost_d;
            best_q   <= best_d;
            best_m_q <= best_m_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial fan-out and status outputs
    logic din_s1_q, din_s2_q;
    logic lb_q, lb_d, pri_q, pri_d, sec_q, sec_d, byp_q, byp_d, lk_q, lk_d;

    always_comb begin
        lb_d  = strap_q.loopback_en && !drv_out_q[`RCD_DRV_LB_OFF_BIT] && din_s2_q;
        pri_d = din_s2_q;
        sec_d = strap_q.secondary_en && !drv_out_q[`RCD_DRV_SEC_OFF_BIT] && din_s2_q;
        byp_d = !rate_ok;
        lk_d  = locked ^ lock_cfg_q[`RCD_LOCK_INV_BIT];
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
            lb_q     <= 1'b0;
            pri_q    <= 1'b0;
            sec_q    <= 1'b0;
            byp_q    <= 1'b1;
            lk_q     <= 1'b0;
        end else begin
            din_s1_q <= DIFF_SERIAL_INPUT_I;
            din_s2_q <= din_s1_q;
            lb_q     <= lb_d;
            pri_q    <= pri_d;
            sec_q    <= sec_d;
            byp_q    <= byp_d;
            lk_q     <= lk_d;
        end
    end

    assign REG_RDATA_O              = rdata_q;
    assign REG_ACK_O                = ack_q;
    assign SPI_MODE_O               = strap_q.spi_mode;
    assign STRAP_DONE_O             = strap_done_q;
    assign EYE_MON_EN_O             = mon_en;
    assign EQ_BOOST_O               = 4'(boost_q);
    assign BYPASS_O                 = byp_q;
    assign LOCK_IND_O               = lk_q;
    assign LOOPBACK_DIFF_OUTPUT_O   = lb_q;
    assign PRIMARY_CABLE_OUTPUT_O   = pri_q;
    assign SECONDARY_CABLE_OUTPUT_O = sec_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence page_wr_s(logic [2:0] c);
        req.wr && req.addr == `RCD_PAGE_SEL_ADDR && req.wdata[2:0] == c;
    endsequence

    sequence apply_s;
        eq_q == EQ_APPLY ##1 eq_q == EQ_LOCK;
    endsequence

    page_reset_a: assert property (disable iff (1'b0) $past(RST_I) && !RST_I |-> page_q == `RCD_PAGE_SHARE)
        else $error("page not shared after reset");
    page_share_a: assert property (page_wr_s(`RCD_PAGE_SHARE) |=> page_q == `RCD_PAGE_SHARE)
        else $error("shared page not selected");
    page_eq_a: assert property (page_wr_s(`RCD_PAGE_EQ) |=> page_q == `RCD_PAGE_EQ)
        else $error("equalizer page not selected");
    page_drv_a: assert property (page_wr_s(`RCD_PAGE_DRV) |=> page_q == `RCD_PAGE_DRV)
        else $error("driver page not selected");
    page_reach_a: assert property (req.rd && req.addr == `RCD_PAGE_SEL_ADDR |=> REG_ACK_O && REG_RDATA_O == {5'h00, $past(page_q)})
        else $error("page register read wrong");
    page_rsvd_a: assert property (req.rd && !req.wr && !page_legal && req.addr != `RCD_PAGE_SEL_ADDR |=> REG_RDATA_O == 8'h00)
        else $error("reserved page leaked data");
    eye_apply_a: assert property (apply_s |-> boost_q == $past(best_q) && locked)
        else $error("best boost not applied at lock");
    eye_off_a: assert property (req.wr && page_q == `RCD_PAGE_EQ && req.addr == `RCD_EYE_MON_ADDR &&
                                !req.wdata[`RCD_EYE_MON_BIT] |=> !EYE_MON_EN_O)
        else $error("monitor on while disabled");
    lock_keep_a: assert property (eq_q == EQ_LOCK && sig_ok && adaptive && $fell(mon_en) |-> eq_q == EQ_LOCK ##1 eq_q == EQ_LOCK)
        else $error("lock lost on monitor off");
    manual_lock_a: assert property (eq_q == EQ_IDLE && sig_ok && !adaptive ##1 sig_ok && !adaptive |-> locked)
        else $error("manual mode did not lock");
    bypass_a: assert property (!rate_ok |=> BYPASS_O && !locked)
        else $error("unsupported rate not bypassed");
    strap_lb_a: assert property (strap_done_q && !strap_q.loopback_en |-> ##1 !LOOPBACK_DIFF_OUTPUT_O)
        else $error("loop-back active while strapped off");
    fanout_a: assert property (strap_done_q && strap_q.secondary_en && drv_out_q == 8'h00 ##1 1'b1 |-> SECONDARY_CABLE_OUTPUT_O == PRIMARY_CABLE_OUTPUT_O)
        else $error("cable outputs differ");
endmodule
`default_nettype wire

// ==== core/rcd_cfg_map.svh ====
// Purpose: Offsets, field positions, reset values and counts of the reclocking driver configuration block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
//
// Overview of operation
// - Page code 000 selects shared page.
// - Shared page is active after reset.
// - Page code 100 selects equalizer/recovery page.
// - Page code 101 selects driver page.
// - Shared page holds ID and lock-pin setup.
// - Equalizer page holds EQ, mux, recovery, overrides.
// - Driver page holds loop-back and cable settings.
// - Adaptive mode picks widest-eye boost before lock.
// - Bit 7 clear stops monitor; lock stays.
// - Manual mode ignores monitor for lock.
// - Unsupported input rates bypass the reclocker.
// - Interface strap: floating SPI, low SMBus.
// - Loop-back strap high disables loop-back output.
// - Loop-back strap low enables loop-back output.
// - Secondary strap low enables second cable output.
// - All enabled outputs carry the input data.
// - Interface strap high also selects SPI.
`ifndef RCD_CFG_MAP_SVH
`define RCD_CFG_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define RCD_PAGE_SEL_ADDR   8'hFF
`define RCD_EYE_MON_ADDR    8'h3E
`define RCD_DEV_ID_ADDR     8'h00
`define RCD_LOCK_CFG_ADDR   8'h01
`define RCD_EQ_MODE_ADDR    8'h31
`define RCD_EQ_STAT_ADDR    8'h32
`define RCD_DRV_OUT_ADDR    8'h10

////////////////////////////////////////////////////////////////////////////////
// Page codes and fields
`define RCD_PAGE_SHARE      3'h0
`define RCD_PAGE_EQ         3'h4
`define RCD_PAGE_DRV        3'h5
`define RCD_EYE_MON_BIT     7
`define RCD_LOCK_INV_BIT    0
`define RCD_EQ_ADAPT_BIT    0
`define RCD_EQ_BOOST_LSB    1
`define RCD_DRV_LB_OFF_BIT  0
`define RCD_DRV_SEC_OFF_BIT 1

////////////////////////////////////////////////////////////////////////////////
// Reset values and counts
`define RCD_EYE_MON_RST     8'h80
`define RCD_LOCK_CFG_RST    8'h00
`define RCD_EQ_MODE_RST     8'h01
`define RCD_DRV_OUT_RST     8'h00
`define RCD_DEV_ID_VAL      8'h5A // Arbitrary value
`define RCD_STRAP_SETTLE    8'h10

`endif

// ==== core/rcd_cfg_pkg.sv ====
// Purpose: Types shared by the reclocking driver configuration block
// Assumes: Constants live in rcd_cfg_map.svh
// Notes:   Types only
package rcd_cfg_pkg;

    typedef enum logic [1:0] {
        LVL_L = 2'b00,
        LVL_R = 2'b01,
        LVL_F = 2'b10,
        LVL_H = 2'b11
    } rcd_level_type;

    typedef enum logic [2:0] {
        EQ_IDLE   = 3'b000,
        EQ_SWEEP  = 3'b001,
        EQ_APPLY  = 3'b010,
        EQ_LOCK   = 3'b011,
        EQ_MANUAL = 3'b100
    } rcd_eq_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcd_req_type;

    typedef struct packed {
        logic spi_mode;
        logic loopback_en;
        logic secondary_en;
    } rcd_strap_type;

endpackage

// ==== core/rcd_page_bank.sv ====
// Purpose: Byte storage for one register page
// Assumes: Single clock, synchronous active-high reset
// Notes:   Unwritten bytes read as zero; dedicated registers live in the top
`timescale 1ns/1ps
`default_nettype none
module rcd_page_bank
    import rcd_cfg_pkg::*;
#(
    parameter int DEPTH = 256
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Access
    input  wire logic                     wr_i,
    input  wire logic [$clog2(DEPTH)-1:0] addr_i,
    input  wire logic [7:0]               wdata_i,
    output logic      [7:0]               rdata_o
);
    logic [7:0]       mem [DEPTH];
    logic [DEPTH-1:0] valid_q;
    logic [DEPTH-1:0] valid_d;

    always_comb begin
        valid_d = valid_q;
        if (wr_i) begin
            valid_d[addr_i] = 1'b1;
        end
    end

    // Valid bits keep never-written bytes from reading as unknowns
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= '0;
        end else begin
            valid_q <= valid_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = valid_q[addr_i] ? mem[addr_i] : 8'h00;
endmodule
`default_nettype wire

// ==== verif/rcd_host_model.sv ====
// Purpose: Host side model issuing framed register requests
// Assumes: One request pulse per access, answer one edge later
// Notes:   Released address and data are inverted so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module rcd_host_model (
    // Clock
    input  wire logic       clk_i,
    // Request side
    output logic            wr_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    // Answer side
    input  wire logic [7:0] rdata_i,
    input  wire logic       ack_i
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    ////////////////////////////////////////
    // One-cycle pulse, then sample the answer after the taking edge
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= ~w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        ok = ack_i;
        q = rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== verif/rcd_cfg_top_tb.sv ====
// Purpose: Self-checking bench for the paged configuration block
// Assumes: Host model speaks the framed request pulses
// Notes:   BOOST_STEPS cut to 4 so a sweep ends in a few cycles
`timescale 1ns/1ps
`default_nettype none
module rcd_cfg_top_tb;
    import rcd_cfg_pkg::*;
    localparam logic [7:0] DEVID = 8'h3C; // Arbitrary value
    logic       clk = 1'b0, rst = 1'b1, sig_det = 1'b0, eye_valid = 1'b0, din = 1'b0;
    logic [1:0] st_mode = LVL_F, st_lb = LVL_H, st_sec = LVL_H;
    logic [2:0] rate = 3'h0;
    logic [7:0] eye_h = 8'h00, eye_v = 8'h00, addr, wdata, rdata, q;
    logic       wr, rd, ack, spi, done, mon_en, bypass, lock, lb_out, pri_out, sec_out, ok;
    logic [3:0] boost;
    int         bad_count = 0, check_count = 0;

    always #20 clk = ~clk;

    rcd_cfg_top #(.BOOST_STEPS(4), .DEV_ID(DEVID)) dut (
        .CLK_I(clk), .RST_I(rst), .MODE_STRAP_I(st_mode), .LOOPBACK_SELECT_STRAP_I(st_lb),
        .SECONDARY_OUTPUT_SELECT_STRAP_I(st_sec), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_ACK_O(ack), .SPI_MODE_O(spi),
        .STRAP_DONE_O(done), .SIGNAL_DET_I(sig_det), .RATE_CODE_I(rate), .EYE_VALID_I(eye_valid),
        .EYE_H_I(eye_h), .EYE_V_I(eye_v), .EYE_MON_EN_O(mon_en), .EQ_BOOST_O(boost),
        .BYPASS_O(bypass), .LOCK_IND_O(lock), .DIFF_SERIAL_INPUT_I(din),
        .LOOPBACK_DIFF_OUTPUT_O(lb_out), .PRIMARY_CABLE_OUTPUT_O(pri_out),
        .SECONDARY_CABLE_OUTPUT_O(sec_out));

    rcd_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
        .rdata_i(rdata), .ack_i(ack));

    ////////////////////////////////////////
    task automatic chk_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q, ok);
        chk_bit("write ack", 1'b1, ok);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        host.access(1'b0, a, 8'h00, q, ok);
        chk_bit("read ack", 1'b1, ok);
        chk_byte($sformatf("reg %h", a), exp, q);
    endtask
    task automatic do_reset(input logic [1:0] m, input logic [1:0] l, input logic [1:0] s);
        st_mode <= m;
        st_lb <= l;
        st_sec <= s;
        sig_det <= 1'b0;
        rate <= 3'h0;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk);
        #1;
        chk_bit("strap done", 1'b1, done);
    endtask
    task automatic wait_lock;
        for (int i = 0; i < 30 && lock !== 1'b1; i++) @(posedge clk);
        #1;
    endtask
    task automatic eye(input logic [7:0] h, input logic [7:0] v);
        @(posedge clk);
        eye_valid <= 1'b1;
        eye_h <= h;
        eye_v <= v;
        @(posedge clk);
        eye_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////
    task automatic t_pages;
        do_reset(LVL_F, LVL_H, LVL_H);
        chk_bit("bypass idle", 1'b1, bypass);
        rreg(8'h00, DEVID);
        wreg(8'hFF, 8'h04);
        rreg(8'h3E, 8'h80);
        chk_bit("monitor on", 1'b1, mon_en);
        rreg(8'hFF, 8'h04);
        wreg(8'hFF, 8'h05);
        wreg(8'h10, 8'h02);
        rreg(8'h10, 8'h02);
        rreg(8'h3E, 8'h00);
        wreg(8'hFF, 8'h07);
        wreg(8'h10, 8'hAA);
        rreg(8'h10, 8'h00);
        wreg(8'hFF, 8'h05);
        rreg(8'h10, 8'h02);
        wreg(8'hFF, 8'h00);
        rreg(8'h00, DEVID);
        $display("test pages done");
    endtask

    // Straps are latched once, so every case needs its own reset
    task automatic t_straps;
        logic [1:0] m[4] = '{LVL_F, LVL_L, LVL_H, LVL_R};
        logic [1:0] l[4] = '{LVL_H, LVL_L, LVL_R, LVL_L};
        logic [1:0] s[4] = '{LVL_H, LVL_L, LVL_F, LVL_R};
        logic       e_spi[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic       e_lb[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic       e_sec[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            do_reset(m[i], l[i], s[i]);
            chk_bit("spi mode", e_spi[i], spi);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                din <= v[0];
                repeat (4) @(posedge clk);
                #1;
                chk_bit("primary out", v[0], pri_out);
                chk_bit("loopback out", v[0] & e_lb[i], lb_out);
                chk_bit("secondary out", v[0] & e_sec[i], sec_out);
            end
        end
        $display("test straps done");
    endtask

    task automatic t_adapt;
        do_reset(LVL_F, LVL_L, LVL_L);
        @(posedge clk);
        sig_det <= 1'b1;
        rate <= 3'h1;
        repeat (3) @(posedge clk);
        #1;
        chk_bit("bypass rate ok", 1'b0, bypass);
        eye(8'h08, 8'h08);
        eye(8'h30, 8'h20);
        eye(8'h20, 8'h10);
        eye(8'h28, 8'h28);
        wait_lock;
        chk_bit("adaptive lock", 1'b1, lock);
        chk_byte("best boost", 8'h01, {4'h0, boost});
        wreg(8'hFF, 8'h04);
        rreg(8'h32, 8'h81);
        wreg(8'h3E, 8'h00);
        chk_bit("monitor off", 1'b0, mon_en);
        repeat (10) @(posedge clk);
        #1;
        chk_bit("lock kept", 1'b1, lock);
        @(posedge clk);
        rate <= 3'h6;
        repeat (3) @(posedge clk);
        #1;
        chk_bit("bypass other rate", 1'b1, bypass);
        $display("test adaptive done");
    endtask

    task automatic t_manual;
        do_reset(LVL_H, LVL_H, LVL_H);
        wreg(8'hFF, 8'h04);
        wreg(8'h3E, 8'h00);
        wreg(8'h31, 8'h06);
        @(posedge clk);
        sig_det <= 1'b1;
        rate <= 3'h5;
        wait_lock;
        chk_bit("manual lock", 1'b1, lock);
        chk_byte("manual boost", 8'h03, {4'h0, boost});
        wreg(8'hFF, 8'h00);
        wreg(8'h01, 8'h01);
        rreg(8'h01, 8'h01);
        chk_bit("lock inverted", 1'b0, lock);
        $display("test manual done");
    endtask

    ////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 40);
        bad_count++;
        $display("watchdog expired");
        give_verdict;
    end

    initial begin
        t_pages;
        t_straps;
        t_adapt;
        t_manual;
        give_verdict;
    end
endmodule
`default_nettype wire
